// ### hw/htr_crc7.sv
`timescale 1ns/1ps
module htr_crc7
  import htr_pkg::*;
(
  // payload in, checksum out
  input  wire logic [16:0] payload_i,
  output logic      [6:0]  crc_o
);
  always_comb begin
    logic [6:0] c;
    logic       fb;
    c  = 7'h00;
    fb = 1'b0;
    for (int i = PAYLOAD_W - 1; i >= 0; i--) begin // RQ5
      fb = c[6] ^ payload_i[i];
      c  = {c[5:0], 1'b0} ^ (fb ? CRC_POLY : 7'h00); // RQ4
    end
    // init vector sits in the appended tail, so it folds in last
    crc_o = c ^ CRC_INIT; // RQ4
  end
endmodule : htr_crc7

// ### hw/htr_pkg.sv
package htr_pkg;
  // byte addresses of the register map
  localparam logic [7:0] ADDR_IDENTITY       = 8'h00;
  localparam logic [7:0] ADDR_UNIQUE_ID      = 8'h04;
  localparam logic [7:0] ADDR_SYSTEM_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_SYSTEM_STATUS  = 8'h11;
  localparam logic [7:0] ADDR_RUN            = 8'h21;
  localparam logic [7:0] ADDR_START          = 8'h22;
  localparam logic [7:0] ADDR_STOP           = 8'h23;
  localparam logic [7:0] ADDR_SENSOR_STATUS  = 8'h24;
  localparam logic [7:0] ADDR_T_RES          = 8'h30;
  localparam logic [7:0] ADDR_H_RES          = 8'h33;
  localparam int         RES_BYTES           = 3;
  localparam int         UNIQUE_ID_BYTES     = 8;
  // reset values
  localparam logic       LOW_POWER_RST = 1'b1;
  localparam logic [1:0] RUN_RST       = 2'h0;
  // arbitrary identity values
  localparam logic [15:0] IDENTITY_DFLT  = 16'hA5C3;
  localparam logic [63:0] UNIQUE_ID_DFLT = 64'h0123_4567_89AB_CDEF;
  // checksum
  localparam int         CRC_W         = 7;
  localparam int         PAYLOAD_W     = 17;
  localparam logic [6:0] CRC_INIT      = 7'h7F;
  localparam logic [6:0] CRC_POLY      = 7'h09;
  // field positions in the readout word
  localparam int         VALID_POS     = 16;
  localparam int         CRC_POS       = 17;
  // unit scale: temperature 1/64 K, humidity 1/512 percent
  localparam int         T_LSB_PER_K   = 64;
  localparam int         H_LSB_PER_PCT = 512;

  typedef struct packed {
    logic [6:0]  crc;
    logic        valid;
    logic [15:0] data;
  } htr_word_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } htr_req_t;

  // byte select of a 24-bit word, lowest byte first
  function automatic logic [7:0] htr_byte(input logic [23:0] w,
                                          input logic [1:0] idx);
    case (idx)
      2'd0:    htr_byte = w[7:0];
      2'd1:    htr_byte = w[15:8];
      2'd2:    htr_byte = w[23:16];
      default: htr_byte = 8'h00;
    endcase
  endfunction : htr_byte
endpackage : htr_pkg

// ### hw/htr_regs.sv
// Requirements this block is written against
// RQ1: results are three bytes, low byte first
// RQ2: result holds data, valid bit, checksum
// RQ3: 16-bit data in the low bits
// RQ4: CRC-7, poly x7+x3+1, init 0x7F
// RQ5: CRC over data and valid, stored above
// RQ6: starting a measurement clears valid
// RQ7: completion sets valid with data, checksum
// RQ8: continuous follow-on keeps valid set
// RQ9: first-byte read snapshots whole result
// RQ10: higher bytes read from the snapshot
// RQ11: data bytes readable without the rest
// RQ12: temperature in 1/64 kelvin units
// RQ13: humidity in 1/512 percent units
// RQ14: identity readable only while active
// RQ15: host disables low power to read ids
// RQ16: host may piggyback id read on measurement
// RQ17: fixed byte addresses of the map
// RQ18: reserved reads zero, bad writes nacked
// RQ19: status bit set only while active
// RQ20: low-power enable bit, resets to one
// RQ21: checksum stored atomically with data
`timescale 1ns/1ps
module htr_regs
  import htr_pkg::*;
#(
  parameter logic [15:0] IDENTITY  = IDENTITY_DFLT,
  parameter logic [63:0] UNIQUE_ID = UNIQUE_ID_DFLT
)(
  // clock, reset, enable
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  // register access from the serial slave
  input  htr_req_t         req_i,
  output logic      [7:0]  rdata_o,
  output logic             wr_ack_o,
  // measurement engine
  input  wire logic        awake_i,
  input  wire logic [1:0]  busy_i,
  input  wire logic [1:0]  done_i,
  input  wire logic [15:0] t_data_i,
  input  wire logic [15:0] h_data_i,
  output logic      [1:0]  start_o,
  output logic      [1:0]  follow_o,
  output logic      [1:0]  run_mode_o,
  output logic      [1:0]  stop_pend_o,
  output logic             low_power_o,
  output logic             dev_reset_o
);
  logic       low_power_reg, low_power_next;
  logic [1:0] run_reg, run_next;
  logic [1:0] start_pend_reg, start_pend_next;
  logic [1:0] stop_reg, stop_next;
  logic [1:0] busy_q_reg, busy_q_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       rst_pulse_reg, rst_pulse_next;
  logic [1:0] go, cont, snap;
  htr_word_t  live [2];
  htr_word_t  shadow [2];
  logic [15:0] sens_data [2];

  assign sens_data[0] = t_data_i; // RQ12
  assign sens_data[1] = h_data_i; // RQ13

  // start a sensor once it is idle and a start is pending
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      go[s]   = start_pend_reg[s] & ~busy_i[s] & ~busy_q_reg[s];
      cont[s] = done_i[s] & run_reg[s] & ~stop_reg[s]; // RQ8
    end
  end

  assign snap[0] = req_i.rd && (req_i.addr == ADDR_T_RES); // RQ9
  assign snap[1] = req_i.rd && (req_i.addr == ADDR_H_RES); // RQ9

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_res
      htr_result u_res (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .ce_i      (ce_i),
        .start_i   (go[g]),
        .follow_i  (cont[g]),
        .done_i    (done_i[g]),
        .data_i    (sens_data[g]),
        .snap_i    (snap[g]),
        .live_o    (live[g]),
        .shadow_o  (shadow[g])
      );
    end
  endgenerate

  // byte read decode
  function automatic logic [7:0] rd_byte(input logic [7:0] a,
                                         input logic       awake,
                                         input htr_word_t  t_live,
                                         input htr_word_t  t_sh,
                                         input htr_word_t  h_live,
                                         input htr_word_t  h_sh);
    rd_byte = 8'h00; // RQ18
    if (a == ADDR_T_RES) begin
      rd_byte = htr_byte(t_live, 2'd0); // RQ1 RQ9
    end else if (a > ADDR_T_RES && a < ADDR_H_RES) begin
      rd_byte = htr_byte(t_sh, 2'(a - ADDR_T_RES)); // RQ10 RQ11
    end else if (a == ADDR_H_RES) begin
      rd_byte = htr_byte(h_live, 2'd0); // RQ9
    end else if (a > ADDR_H_RES && a < ADDR_H_RES + 8'(RES_BYTES)) begin
      rd_byte = htr_byte(h_sh, 2'(a - ADDR_H_RES)); // RQ10
    end else if (awake && a < ADDR_IDENTITY + 8'h02) begin
      rd_byte = IDENTITY[8*a[0] +: 8]; // RQ14
    end else if (awake && a >= ADDR_UNIQUE_ID &&
                 a < ADDR_UNIQUE_ID + 8'(UNIQUE_ID_BYTES)) begin
      rd_byte = UNIQUE_ID[8*(3'(a - ADDR_UNIQUE_ID)) +: 8]; // RQ14
    end
    return rd_byte;
  endfunction : rd_byte

  always_comb begin
    low_power_next  = low_power_reg;
    run_next        = run_reg;
    start_pend_next = start_pend_reg & ~go;
    stop_next       = stop_reg;
    busy_q_next     = busy_i;
    rst_pulse_next  = 1'b0;
    rdata_next      = rdata_reg;
    for (int s = 0; s < 2; s++) begin
      // stop is effected once, at completion
      if (done_i[s] && !cont[s]) begin
        stop_next[s] = 1'b0;
      end
    end
    if (req_i.rd) begin
      rdata_next = rd_byte(req_i.addr, awake_i, live[0], shadow[0],
                           live[1], shadow[1]);
    end
    if (req_i.wr) begin
      case (req_i.addr) // RQ17
        ADDR_SYSTEM_CONTROL: begin
          low_power_next = req_i.wdata[0]; // RQ20
          rst_pulse_next = req_i.wdata[7];
        end
        ADDR_RUN: begin
          if (busy_i == 2'b00) begin
            run_next = req_i.wdata[1:0];
          end
        end
        ADDR_START: begin
          start_pend_next = start_pend_next | req_i.wdata[1:0];
        end
        ADDR_STOP: begin
          stop_next = stop_next | (req_i.wdata[1:0] & run_reg);
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    case (req_i.addr)
      ADDR_SYSTEM_CONTROL, ADDR_RUN, ADDR_START, ADDR_STOP:
        wr_ack_o = 1'b1;
      default: wr_ack_o = 1'b0; // RQ18
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      low_power_reg  <= LOW_POWER_RST; // RQ20
      run_reg        <= RUN_RST;
      start_pend_reg <= 2'h0;
      stop_reg       <= 2'h0;
      busy_q_reg     <= 2'h0;
      rdata_reg      <= 8'h00;
      rst_pulse_reg  <= 1'b0;
    end else if (ce_i) begin
      low_power_reg  <= low_power_next;
      run_reg        <= run_next;
      start_pend_reg <= start_pend_next;
      stop_reg       <= stop_next;
      busy_q_reg     <= busy_q_next;
      rdata_reg      <= rdata_next;
      rst_pulse_reg  <= rst_pulse_next;
    end
  end

  // status reads use their own registered byte, muxed onto rdata_o
  logic [7:0] stat_byte;
  always_comb begin
    stat_byte = 8'h00;
    if (req_i.addr == ADDR_SYSTEM_STATUS) begin
      stat_byte = {7'h00, awake_i}; // RQ19
    end else if (req_i.addr == ADDR_SYSTEM_CONTROL) begin
      stat_byte = {7'h00, low_power_reg};
    end else if (req_i.addr == ADDR_RUN) begin
      stat_byte = {6'h00, run_reg};
    end else if (req_i.addr == ADDR_SENSOR_STATUS) begin
      stat_byte = {6'h00, busy_i};
    end
  end

  logic [7:0] stat_reg, stat_next;
  logic       stat_sel_reg, stat_sel_next;
  always_comb begin
    stat_next     = stat_reg;
    stat_sel_next = stat_sel_reg;
    if (req_i.rd) begin
      stat_next     = stat_byte;
      stat_sel_next = (stat_byte != 8'h00) ||
                      req_i.addr == ADDR_SYSTEM_STATUS ||
                      req_i.addr == ADDR_SYSTEM_CONTROL ||
                      req_i.addr == ADDR_RUN ||
                      req_i.addr == ADDR_SENSOR_STATUS;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      stat_reg     <= 8'h00;
      stat_sel_reg <= 1'b0;
    end else if (ce_i) begin
      stat_reg     <= stat_next;
      stat_sel_reg <= stat_sel_next;
    end
  end

  assign rdata_o     = stat_sel_reg ? stat_reg : rdata_reg;
  assign start_o     = go; // RQ6
  assign follow_o    = cont; // RQ8
  assign run_mode_o  = run_reg;
  assign stop_pend_o = stop_reg;
  assign low_power_o = low_power_reg;
  assign dev_reset_o = rst_pulse_reg;
endmodule : htr_regs

// ### hw/htr_result.sv
`timescale 1ns/1ps
module htr_result
  import htr_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  // measurement events
  input  wire logic        start_i,
  input  wire logic        follow_i,
  input  wire logic        done_i,
  input  wire logic [15:0] data_i,
  // snapshot
  input  wire logic        snap_i,
  output htr_word_t        live_o,
  output htr_word_t        shadow_o
);
  htr_word_t  live_reg, live_next, shadow_reg, shadow_next;
  logic [6:0] crc;

  htr_crc7 u_crc (
    .payload_i ({1'b1, data_i}),
    .crc_o     (crc)
  );

  always_comb begin
    live_next   = live_reg;
    shadow_next = shadow_reg;
    if (done_i) begin
      live_next = '{crc: crc, valid: 1'b1, data: data_i}; // RQ2 RQ3 RQ7 RQ21
    end else if (start_i && !follow_i) begin
      live_next.valid = 1'b0; // RQ6 RQ8
      live_next.crc   = 7'h00;
    end
    if (snap_i) begin
      shadow_next = live_reg; // RQ9
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      live_reg   <= '0;
      shadow_reg <= '0;
    end else if (ce_i) begin
      live_reg   <= live_next;
      shadow_reg <= shadow_next;
    end
  end

  assign live_o   = live_reg;
  assign shadow_o = shadow_reg;
endmodule : htr_result

// ### sim/htr_host_model.sv
`timescale 1ns/1ps
module htr_host_model
  import htr_pkg::*;
(
  // clock
  input  wire logic       ref_clk_i,
  // register access
  input  wire logic [7:0] rdata_i,
  input  wire logic       ack_i,
  output htr_req_t        req_o
);
  initial req_o = '0;
  // request held until the taking edge, answer read after it
  task xfer(input logic w, input logic [7:0] a, d,
            output logic [7:0] q, output logic k);
    // one idle edge keeps a release and the next request apart
    @(posedge ref_clk_i) #1;
    req_o = '{wr: w, rd: !w, addr: a, wdata: d};
    #1 k = ack_i;
    @(posedge ref_clk_i) #1;
    q = rdata_i;
    req_o = '0;
  endtask : xfer
endmodule : htr_host_model

// ### sim/htr_regs_properties.sv
`timescale 1ns/1ps
module htr_regs_properties
  import htr_pkg::*;
#(
  parameter logic [15:0] IDENTITY = IDENTITY_DFLT
)(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  // register access
  input  htr_req_t         req_i,
  input  wire logic [7:0]  rdata_o,
  input  wire logic        wr_ack_o,
  // engine side
  input  wire logic        awake_i,
  input  wire logic [1:0]  busy_i,
  input  wire logic [1:0]  done_i,
  input  wire logic [15:0] t_data_i,
  input  wire logic [1:0]  start_o,
  input  wire logic [1:0]  follow_o,
  input  wire logic [1:0]  run_mode_o,
  input  wire logic [1:0]  stop_pend_o
);
  logic        rd;
  logic [15:0] t_last_reg;
  assign rd = ce_i & req_i.rd;
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i)
      t_last_reg <= 16'h0000;
    else if (ce_i && done_i[0])
      t_last_reg <= t_data_i;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  a_ack_map: assert property (
    wr_ack_o == (req_i.addr inside {8'h10, 8'h21, 8'h22, 8'h23}))
    else $error("write ack wrong");
  a_rsvd_zero: assert property (
    rd && req_i.addr >= 8'h36 |=> rdata_o == 8'h00) else $error("rsvd");
  a_id_asleep: assert property (
    rd && req_i.addr == ADDR_IDENTITY && !awake_i |=> rdata_o == 8'h00)
    else $error("id visible asleep");
  a_id_awake: assert property (
    rd && req_i.addr == ADDR_IDENTITY && awake_i |=> rdata_o == IDENTITY[7:0])
    else $error("id byte wrong");
  a_stat_awake: assert property (
    rd && req_i.addr == ADDR_SYSTEM_STATUS
    |=> rdata_o == {7'h00, $past(awake_i)})
    else $error("status wrong");
  a_low_byte: assert property (
    rd && req_i.addr == ADDR_T_RES && !done_i[0]
    |=> rdata_o == t_last_reg[7:0]) else $error("low byte wrong");
  a_start_go: assert property (
    ce_i && req_i.wr && req_i.addr == ADDR_START && req_i.wdata[0] &&
    !busy_i[0] ##1 !busy_i[0] |-> start_o[0]) else $error("no start");
  a_follow_on: assert property (
    done_i[0] |-> follow_o[0] == (run_mode_o[0] && !stop_pend_o[0]))
    else $error("follow wrong");
endmodule : htr_regs_properties

bind htr_regs htr_regs_properties #(.IDENTITY(IDENTITY)) u_props (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .req_i(req_i),
  .rdata_o(rdata_o), .wr_ack_o(wr_ack_o), .awake_i(awake_i),
  .busy_i(busy_i), .done_i(done_i), .t_data_i(t_data_i),
  .start_o(start_o), .follow_o(follow_o), .run_mode_o(run_mode_o),
  .stop_pend_o(stop_pend_o));

// ### sim/htr_regs_tb_top.sv
`timescale 1ns/1ps
module htr_regs_tb_top
  import htr_pkg::*;
();
  logic        ref_clk_i, nrst_i, ce_i, awake_i, ack, low_power, dev_rst;
  logic [1:0]  busy_i, done_i, start, follow, run_mode, stop_pend;
  logic [15:0] t_data_i, h_data_i;
  logic [7:0]  rdata, q;
  htr_req_t    req;
  int          miscompares, total_checks;
  htr_regs DUT (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .req_i(req), .rdata_o(rdata), .wr_ack_o(ack), .awake_i(awake_i),
    .busy_i(busy_i), .done_i(done_i), .t_data_i(t_data_i),
    .h_data_i(h_data_i), .start_o(start), .follow_o(follow),
    .run_mode_o(run_mode), .stop_pend_o(stop_pend),
    .low_power_o(low_power), .dev_reset_o(dev_rst));
  htr_host_model HOST (.ref_clk_i(ref_clk_i), .rdata_i(rdata),
    .ack_i(ack), .req_o(req));
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  task chk(input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, d, input logic k);
    logic g;
    HOST.xfer(1'b1, a, d, q, g);
    chk({7'h00, g}, {7'h00, k});
  endtask : wr
  task rd(input logic [7:0] a);
    logic g;
    HOST.xfer(1'b0, a, 8'h00, q, g);
  endtask : rd
  task rc(input logic [7:0] a, e);
    rd(a);
    chk(q, e);
  endtask : rc
  task meas(input logic [1:0] s, input logic [15:0] d, input logic f);
    @(posedge ref_clk_i) #1;
    busy_i = s;
    @(posedge ref_clk_i) #1;
    done_i = s;
    t_data_i = d;
    h_data_i = d;
    #1 chk({7'h00, follow[0]}, {7'h00, f});
    @(posedge ref_clk_i) #1;
    done_i = 2'h0;
    busy_i = 2'h0;
    t_data_i = ~d;
    h_data_i = ~d;
  endtask : meas
  task t_map;
    logic [7:0] ad [8];
    ad = '{8'h00, 8'h11, 8'h24, 8'h30, 8'h33, 8'h0C, 8'h36, 8'hFF};
    foreach (ad[i]) begin
      wr(ad[i], 8'hFF, 1'b0);
      rc(ad[i], 8'h00);
    end
    rc(ADDR_SYSTEM_CONTROL, 8'h01);
    rc(ADDR_RUN, 8'h00);
  endtask : t_map
  task t_freeze;
    ce_i = 1'b0;
    wr(ADDR_SYSTEM_CONTROL, 8'h00, 1'b1);
    ce_i = 1'b1;
    rc(ADDR_SYSTEM_CONTROL, 8'h01);
    wr(ADDR_SYSTEM_CONTROL, 8'h81, 1'b1);
    chk({7'h00, dev_rst}, 8'h01);
    rc(ADDR_SYSTEM_CONTROL, 8'h01);
    chk({7'h00, dev_rst}, 8'h00);
  endtask : t_freeze
  task t_ids;
    wr(ADDR_SYSTEM_CONTROL, 8'h00, 1'b1);
    chk({7'h00, low_power}, 8'h00);
    awake_i = 1'b1;
    rc(ADDR_SYSTEM_STATUS, 8'h01);
    rc(ADDR_IDENTITY, IDENTITY_DFLT[7:0]);
    rc(8'h01, IDENTITY_DFLT[15:8]);
    rc(ADDR_UNIQUE_ID, UNIQUE_ID_DFLT[7:0]);
    rc(8'h0B, UNIQUE_ID_DFLT[63:56]);
    wr(ADDR_SYSTEM_CONTROL, 8'h01, 1'b1);
    awake_i = 1'b0;
    rc(8'h0B, 8'h00);
  endtask : t_ids
  task t_meas;
    wr(ADDR_START, 8'h03, 1'b1);
    chk({6'h00, start}, 8'h03);
    meas(2'h1, 16'h49FD, 1'b0);
    meas(2'h2, 16'h2E6C, 1'b0);
    rc(ADDR_T_RES, 8'hFD);
    rc(8'h31, 8'h49);
    rc(8'h32, 8'h0B);
    rc(ADDR_H_RES, 8'h6C);
    rc(8'h34, 8'h2E);
    rc(8'h35, 8'hF5);
    wr(ADDR_START, 8'h01, 1'b1);
    rc(ADDR_T_RES, 8'hFD);
    rd(8'h32);
    chk({7'h00, q[0]}, 8'h00);
    meas(2'h1, 16'h1234, 1'b0);
    rc(8'h31, 8'h49);
    rc(ADDR_T_RES, 8'h34);
    rc(8'h31, 8'h12);
  endtask : t_meas
  task t_cont;
    wr(ADDR_RUN, 8'h01, 1'b1);
    wr(ADDR_START, 8'h01, 1'b1);
    meas(2'h1, 16'hA5A5, 1'b1);
    rd(ADDR_T_RES);
    rd(8'h32);
    chk({7'h00, q[0]}, 8'h01);
    wr(ADDR_STOP, 8'h01, 1'b1);
    chk({6'h00, stop_pend}, 8'h01);
    meas(2'h1, 16'h5A5A, 1'b0);
    rc(ADDR_T_RES, 8'h5A);
  endtask : t_cont
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  initial begin
    miscompares = 0;
    total_checks = 0;
    nrst_i = 1'b0;
    ce_i = 1'b1;
    awake_i = 1'b0;
    busy_i = 2'h0;
    done_i = 2'h0;
    t_data_i = 16'h0000;
    h_data_i = 16'h0000;
    repeat (5) @(posedge ref_clk_i);
    #1 nrst_i = 1'b1;
    t_map;
    t_freeze;
    t_ids;
    t_meas;
    t_cont;
    close_out;
  end
  initial begin
    #16000;
    miscompares++;
    close_out;
  end
endmodule : htr_regs_tb_top
